/* verilog/mact_pkg.sv */
// Package: operation codes, instruction fields and latency figures
package mact_pkg;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_OTHER,
    OP_PRODUCT_32BIT,
    OP_PRODUCT_ACCUMULATE_32BIT,
    OP_SIGNED_LONG_PRODUCT,
    OP_SIGNED_LONG_PRODUCT_ACC,
    OP_UNSIGNED_LONG_PRODUCT,
    OP_UNSIGNED_LONG_PRODUCT_ACC,
    OP_SIGNED_HALF_PRODUCT,
    OP_SIGNED_HALF_PRODUCT_ACC,
    OP_SIGNED_WORD_HALF_PRODUCT,
    OP_SIGNED_WORD_HALF_ACC,
    OP_SIGNED_HALF_LONG_ACC,
    OP_ACC_PRODUCT_ADD,
    OP_ACC_HALF_PRODUCT_ADD,
    OP_ACC_PACKED_HALF_ADD,
    OP_ACC_LOAD_FROM_REGS,
    OP_ACC_READ_TO_REGS
  } mact_op_t;

  // ----------------------------------------------------------------
  // Sizes and field positions
  // ----------------------------------------------------------------
  localparam int unsigned REG_IDX_W   = 5;
  localparam int unsigned NUM_SRC     = 3;
  localparam int unsigned NUM_ENTRIES = 17;
  localparam int unsigned WAIT_W      = 3;
  localparam logic [REG_IDX_W-1:0] ACC_ENTRY = 5'h10;
  localparam int unsigned ET_TOP         = 31;
  localparam int unsigned ET_WIDE_LSB    = 15;
  localparam int unsigned ET_NARROW_LSB  = 27;
  localparam int unsigned ACC_WIDE_LSB   = 16;
  localparam int unsigned ACC_NARROW_LSB = 28;

  // ----------------------------------------------------------------
  // Latencies in core cycles
  // ----------------------------------------------------------------
  localparam logic [WAIT_W-1:0] WAIT_OPEN    = 3'h1;
  localparam logic [WAIT_W-1:0] LATE_PEN     = 3'h1;
  localparam logic [WAIT_W-1:0] OTHER_ISS    = 3'h1;
  localparam logic [WAIT_W-1:0] MUL_RES_BASE = 3'h2;
  localparam logic [WAIT_W-1:0] MUL_RSC_BASE = 3'h1;
  localparam logic [WAIT_W-1:0] MUL_S_BASE   = 3'h2;
  localparam logic [WAIT_W-1:0] LONG_ACC_ISS = 3'h2;
  localparam logic [WAIT_W-1:0] LONG_LO_BASE = 3'h2;
  localparam logic [WAIT_W-1:0] LONG_S_BASE  = 3'h3;
  localparam logic [WAIT_W-1:0] HI_GAP       = 3'h1;
  localparam logic [WAIT_W-1:0] HALF_RES     = 3'h2;
  localparam logic [WAIT_W-1:0] HALF_RSC     = 3'h1;
  localparam logic [WAIT_W-1:0] WHALF_RES    = 3'h3;
  localparam logic [WAIT_W-1:0] WHALF_RSC    = 3'h2;
  localparam logic [WAIT_W-1:0] HLONG_ISS    = 3'h2;
  localparam logic [WAIT_W-1:0] ACC_BASE     = 3'h1;
  localparam logic [WAIT_W-1:0] ACC_HALF     = 3'h1;
  localparam logic [WAIT_W-1:0] ACC_PACKED   = 3'h2;
  localparam logic [WAIT_W-1:0] ACC_LOAD     = 3'h2;
  localparam logic [WAIT_W-1:0] ACC_READ_LO  = 3'h2;
  localparam logic [WAIT_W-1:0] ACC_READ_RSC = 3'h2;

  typedef struct packed {
    mact_op_t                          op;
    logic                              s;
    logic [31:0]                       opnd;
    logic [REG_IDX_W-1:0]              dlo;
    logic [REG_IDX_W-1:0]              dhi;
    logic [NUM_SRC-1:0][REG_IDX_W-1:0] src;
    logic [NUM_SRC-1:0]                sv;
    logic [NUM_SRC-1:0]                late;
  } mact_instr_t;

  typedef struct packed {
    logic [WAIT_W-1:0] iss;
    logic [WAIT_W-1:0] lo;
    logic [WAIT_W-1:0] hi;
    logic [WAIT_W-1:0] rsc;
    logic              unit;
    logic              wr_lo;
    logic              wr_hi;
    logic              acc_rd;
    logic              acc_wr;
  } mact_lat_t;

endpackage

/* verilog/mact_timing.sv */
// Multiply and accumulator issue timing interlock
`timescale 1ns/1ps
module mact_timing
  import mact_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 instr_valid,
  input  wire mact_op_t             instr_op,
  input  wire logic                 flag_update,
  input  wire logic [31:0]          multiplier_operand,
  input  wire logic [REG_IDX_W-1:0] dest_low_word,
  input  wire logic [REG_IDX_W-1:0] dest_high_word,
  input  wire logic [REG_IDX_W-1:0] src_a_idx,
  input  wire logic [REG_IDX_W-1:0] src_b_idx,
  input  wire logic [REG_IDX_W-1:0] src_c_idx,
  input  wire logic [NUM_SRC-1:0]   src_valid,
  input  wire logic [NUM_SRC-1:0]   src_late,
  output logic                      instr_ready,
  output logic                      issue_fire,
  output mact_op_t                  issue_op
);

  typedef struct packed {
    mact_instr_t [1:0]                       q;
    logic [1:0]                              cnt;
    logic                                    ready;
    logic                                    fire;
    mact_op_t                                fop;
    logic [WAIT_W-1:0]                       issue_wait;
    logic [WAIT_W-1:0]                       mul_wait;
    logic [NUM_ENTRIES-1:0][WAIT_W-1:0]      reg_wait;
  } mact_state_t;

  mact_state_t st;
  mact_state_t next_st;
  mact_instr_t cur;
  mact_instr_t inc;
  mact_lat_t   lat;
  logic [1:0]  cls;
  logic        dep_ok;
  logic        issue_now;
  logic        push;
  logic [1:0]  slot;

  // ----------------------------------------------------------------
  // Early termination class of the multiplier operand
  // ----------------------------------------------------------------
  function automatic logic [1:0] et_class(input mact_op_t op,
                                          input logic [31:0] v);
    logic uns, w0, w1;
    uns = op inside {OP_UNSIGNED_LONG_PRODUCT, OP_UNSIGNED_LONG_PRODUCT_ACC};
    if (op == OP_ACC_PRODUCT_ADD) begin
      w0 = (&v[ET_TOP:ACC_WIDE_LSB]) | ~(|v[ET_TOP:ACC_WIDE_LSB]);
      w1 = (&v[ET_TOP:ACC_NARROW_LSB]) | ~(|v[ET_TOP:ACC_NARROW_LSB]);
    end else begin
      // Unsigned forms treat all-ones as a large value, not as -1
      w0 = ~(|v[ET_TOP:ET_WIDE_LSB])
         | (!uns & (&v[ET_TOP:ET_WIDE_LSB]));
      w1 = ~(|v[ET_TOP:ET_NARROW_LSB])
         | (!uns & (&v[ET_TOP:ET_NARROW_LSB]));
    end
    et_class = w0 ? 2'h0 : (w1 ? 2'h1 : 2'h2);
  endfunction

  // ----------------------------------------------------------------
  // Latency table
  // ----------------------------------------------------------------
  function automatic mact_lat_t lat_of(input mact_op_t op,
                                       input logic s,
                                       input logic [1:0] c);
    mact_lat_t         l;
    logic [WAIT_W-1:0] cx;
    cx = {1'b0, c};
    l = '0;
    l.iss = OTHER_ISS;
    l.unit = (op != OP_OTHER);
    case (op)
      OP_PRODUCT_32BIT, OP_PRODUCT_ACCUMULATE_32BIT: begin
        l.wr_lo = 1'b1;
        if (s) begin
          l.iss = MUL_S_BASE + cx;
          l.lo = l.iss;
          l.rsc = l.iss;
        end else begin
          l.lo = MUL_RES_BASE + cx;
          l.rsc = MUL_RSC_BASE + cx;
        end
      end
      OP_SIGNED_LONG_PRODUCT, OP_SIGNED_LONG_PRODUCT_ACC,
      OP_UNSIGNED_LONG_PRODUCT, OP_UNSIGNED_LONG_PRODUCT_ACC: begin
        l.wr_lo = 1'b1;
        l.wr_hi = 1'b1;
        if (s) begin
          l.iss = LONG_S_BASE + cx;
          l.lo = l.iss;
          l.hi = l.iss;
          l.rsc = l.iss;
        end else begin
          if (op inside {OP_SIGNED_LONG_PRODUCT_ACC,
                         OP_UNSIGNED_LONG_PRODUCT_ACC}) begin
            l.iss = LONG_ACC_ISS;
          end
          l.lo = LONG_LO_BASE + cx;
          l.hi = l.lo + HI_GAP;
          l.rsc = l.lo;
        end
      end
      OP_SIGNED_HALF_PRODUCT, OP_SIGNED_HALF_PRODUCT_ACC: begin
        l.wr_lo = 1'b1;
        l.lo = HALF_RES;
        l.rsc = HALF_RSC;
      end
      OP_SIGNED_WORD_HALF_PRODUCT, OP_SIGNED_WORD_HALF_ACC: begin
        l.wr_lo = 1'b1;
        l.lo = WHALF_RES;
        l.rsc = WHALF_RSC;
      end
      OP_SIGNED_HALF_LONG_ACC: begin
        l.wr_lo = 1'b1;
        l.wr_hi = 1'b1;
        l.iss = HLONG_ISS;
        l.lo = LONG_LO_BASE;
        l.hi = l.lo + HI_GAP;
        l.rsc = HLONG_ISS;
      end
      OP_ACC_PRODUCT_ADD, OP_ACC_HALF_PRODUCT_ADD,
      OP_ACC_PACKED_HALF_ADD: begin
        l.acc_rd = 1'b1;
        l.acc_wr = 1'b1;
        l.lo = (op == OP_ACC_PRODUCT_ADD)      ? ACC_BASE + cx
             : (op == OP_ACC_HALF_PRODUCT_ADD) ? ACC_HALF
             : ACC_PACKED;
        l.rsc = l.lo;
      end
      OP_ACC_LOAD_FROM_REGS: begin
        l.acc_wr = 1'b1;
        l.iss = ACC_LOAD;
        l.lo = ACC_LOAD;
        l.rsc = ACC_LOAD;
      end
      OP_ACC_READ_TO_REGS: begin
        l.acc_rd = 1'b1;
        l.wr_lo = 1'b1;
        l.wr_hi = 1'b1;
        l.lo = ACC_READ_LO;
        l.hi = l.lo + HI_GAP;
        l.rsc = ACC_READ_RSC;
      end
      default: begin
        l.unit = 1'b0;
      end
    endcase
    lat_of = l;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    inc = '{instr_op, flag_update, multiplier_operand,
            dest_low_word, dest_high_word,
            {src_c_idx, src_b_idx, src_a_idx}, src_valid, src_late};
    cur = st.q[0];
    cls = et_class(cur.op, cur.opnd);
    lat = lat_of(cur.op, cur.s, cls);
    // A late consumer needs the counter one lower than a plain one
    dep_ok = 1'b1;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (cur.sv[i] && st.reg_wait[cur.src[i]] >
          (cur.late[i] ? WAIT_OPEN - LATE_PEN : WAIT_OPEN)) begin
        dep_ok = 1'b0;
      end
    end
    if (lat.acc_rd && st.reg_wait[ACC_ENTRY] > WAIT_OPEN) begin
      dep_ok = 1'b0;
    end
    issue_now = (st.cnt != 2'h0) && dep_ok
              && (st.issue_wait <= WAIT_OPEN)
              && (!lat.unit || st.mul_wait <= WAIT_OPEN);
    next_st.issue_wait = st.issue_wait - {2'h0, |st.issue_wait};
    next_st.mul_wait = st.mul_wait - {2'h0, |st.mul_wait};
    for (int e = 0; e < NUM_ENTRIES; e++) begin
      next_st.reg_wait[e] = st.reg_wait[e] - {2'h0, |st.reg_wait[e]};
    end
    if (issue_now) begin
      next_st.issue_wait = lat.iss;
      if (lat.unit) begin
        next_st.mul_wait = lat.rsc;
      end
      if (lat.acc_wr) begin
        next_st.reg_wait[ACC_ENTRY] = lat.lo;
      end
      if (lat.wr_lo) begin
        next_st.reg_wait[cur.dlo] = lat.lo;
      end
      if (lat.wr_hi) begin
        next_st.reg_wait[cur.dhi] = lat.hi;
      end
      next_st.q[0] = st.q[1];
    end
    // Two slots keep one issue per cycle behind a registered ready
    push = instr_valid && st.ready;
    slot = st.cnt - {1'b0, issue_now};
    if (push) begin
      next_st.q[slot[0]] = inc;
    end
    next_st.cnt = slot + {1'b0, push};
    next_st.ready = (next_st.cnt != 2'h2);
    next_st.fire = issue_now;
    next_st.fop = cur.op;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign instr_ready = st.ready;
  assign issue_fire  = st.fire;
  assign issue_op    = st.fop;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking mact_cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  half_latency_a: assert property (
    issue_now && cur.op == OP_SIGNED_WORD_HALF_PRODUCT
    |=> st.mul_wait == 3'h2 && st.reg_wait[$past(cur.dlo)] == 3'h3)
    else $error("word-half latency wrong");
  product_plain_a: assert property (
    issue_now && cur.op == OP_PRODUCT_32BIT && !cur.s && cls == 2'h2
    |=> st.issue_wait == 3'h1 && st.mul_wait == 3'h3
        && st.reg_wait[$past(cur.dlo)] == 3'h4)
    else $error("plain product latency wrong");
  product_flags_a: assert property (
    issue_now && cur.op == OP_PRODUCT_32BIT && cur.s && cls == 2'h1
    |=> !issue_now && st.issue_wait == 3'h3 && st.mul_wait == 3'h3)
    else $error("flagged product latency wrong");
  long_words_a: assert property (
    issue_now && cur.op == OP_SIGNED_LONG_PRODUCT_ACC && !cur.s
    && cur.dlo != cur.dhi
    |=> !issue_now && st.reg_wait[$past(cur.dhi)]
        == st.reg_wait[$past(cur.dlo)] + 3'h1)
    else $error("long product word timing wrong");
  unsigned_class_a: assert property (
    cur.op == OP_UNSIGNED_LONG_PRODUCT && cur.opnd[ET_TOP] |-> cls == 2'h2)
    else $error("unsigned early termination on ones");
  acc_product_a: assert property (
    issue_now && cur.op == OP_ACC_PRODUCT_ADD && cls == 2'h0
    |=> st.reg_wait[ACC_ENTRY] == 3'h1 && st.mul_wait == 3'h1)
    else $error("accumulator product latency wrong");
  acc_load_a: assert property (
    issue_now && cur.op == OP_ACC_LOAD_FROM_REGS
    |=> !issue_now && st.reg_wait[ACC_ENTRY] == 3'h2)
    else $error("accumulator load timing wrong");
  acc_read_a: assert property (
    issue_now && cur.op == OP_ACC_READ_TO_REGS && cur.dlo != cur.dhi
    |=> st.reg_wait[$past(cur.dlo)] == 3'h2
        && st.reg_wait[$past(cur.dhi)] == 3'h3)
    else $error("accumulator read word timing wrong");
  late_use_a: assert property (
    st.cnt != 2'h0 && cur.sv[0] && cur.late[0]
    && st.reg_wait[cur.src[0]] == 3'h1 |-> !issue_now)
    else $error("late consumer issued too early");
  dep_stall_a: assert property (
    st.cnt != 2'h0 && ((lat.unit && st.mul_wait > 3'h1)
    || (cur.sv[0] && st.reg_wait[cur.src[0]] > 3'h1)) |-> !issue_now)
    else $error("issue despite busy unit or pending result");

  back_to_back_c: cover property (issue_now ##1 issue_now);
  late_stall_c: cover property (
    st.cnt != 2'h0 && cur.late[0] && !issue_now ##1 issue_now);
  long_issue_c: cover property (
    issue_now && cur.op == OP_UNSIGNED_LONG_PRODUCT_ACC);

endmodule

/* test/mact_issue_model.sv */
// Issue pipeline model: offers queued instructions and logs issues
`timescale 1ns/1ps
module mact_issue_model
  import mact_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     resetn,
  input  wire logic     instr_ready,
  input  wire logic     issue_fire,
  input  wire mact_op_t issue_op,
  output logic          instr_valid,
  output mact_instr_t   offer
);
  // ------------------------------------------------------------
  // Offer queue and issue log
  // ------------------------------------------------------------
  mact_instr_t pend[$];
  int          cyc;
  int          fire_t[$];
  mact_op_t    fire_op[$];

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      instr_valid <= 1'b0;
      offer       <= '0;
      cyc         <= 0;
      pend.delete();
    end else begin
      cyc <= cyc + 1;
      if (issue_fire) begin
        fire_t.push_back(cyc);
        fire_op.push_back(issue_op);
      end
      // An offer is held until taken, never withdrawn
      if (!instr_valid || instr_ready) begin
        if (pend.size() > 0) begin
          instr_valid <= 1'b1;
          offer       <= pend.pop_front();
        end else begin
          // Idle fields churn so stale values are never trusted
          instr_valid <= 1'b0;
          offer.opnd  <= ~offer.opnd;
          offer.src   <= ~offer.src;
          offer.late  <= ~offer.late;
        end
      end
    end
  end
endmodule

/* test/tb_multiply_accumulate_timing.sv */
// Testbench: issue gaps of multiply forms, queue stall and resets
`timescale 1ns/1ps
module tb_multiply_accumulate_timing
  import mact_pkg::*;
;
  typedef enum {K_IND, K_LO, K_HI, K_ACC, K_UNIT, K_LATE} mact_kind_t;
  typedef struct {
    mact_op_t    op;
    logic        s;
    logic [31:0] v;
    mact_kind_t  k;
    int          gap;
  } mact_row_t;

  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        instr_valid;
  mact_instr_t offer;
  logic        instr_ready;
  logic        issue_fire;
  mact_op_t    issue_op;
  int          fail_count  = 0;
  int          checks_done = 0;

  // ------------------------------------------------------------
  // Rows: first op, flags, operand, follower kind, issue gap
  // ------------------------------------------------------------
  mact_row_t rows[$] = '{
    '{OP_PRODUCT_32BIT, 1'b0, 32'h0, K_IND, 1},
    '{OP_PRODUCT_32BIT, 1'b0, 32'h0, K_LO, 2},
    '{OP_PRODUCT_32BIT, 1'b0, 32'hFFFF8000, K_LO, 2},
    '{OP_PRODUCT_32BIT, 1'b0, 32'h00010000, K_LO, 3},
    '{OP_PRODUCT_32BIT, 1'b0, 32'h00010000, K_UNIT, 2},
    '{OP_PRODUCT_32BIT, 1'b0, 32'h12345678, K_LO, 4},
    '{OP_PRODUCT_32BIT, 1'b0, 32'h12345678, K_UNIT, 3},
    '{OP_PRODUCT_32BIT, 1'b1, 32'h0, K_IND, 2},
    '{OP_PRODUCT_32BIT, 1'b1, 32'hF8001234, K_IND, 3},
    '{OP_PRODUCT_32BIT, 1'b1, 32'h12345678, K_IND, 4},
    '{OP_PRODUCT_ACCUMULATE_32BIT, 1'b0, 32'h12345678, K_LO, 4},
    '{OP_SIGNED_LONG_PRODUCT, 1'b0, 32'h0, K_IND, 1},
    '{OP_SIGNED_LONG_PRODUCT, 1'b0, 32'h0, K_HI, 3},
    '{OP_SIGNED_LONG_PRODUCT, 1'b0, 32'h12345678, K_UNIT, 4},
    '{OP_SIGNED_LONG_PRODUCT, 1'b1, 32'h00010000, K_HI, 4},
    '{OP_SIGNED_LONG_PRODUCT_ACC, 1'b0, 32'h0, K_IND, 2},
    '{OP_UNSIGNED_LONG_PRODUCT, 1'b0, 32'hFFFFFFFF, K_LO, 4},
    '{OP_UNSIGNED_LONG_PRODUCT, 1'b1, 32'h0, K_IND, 3},
    '{OP_UNSIGNED_LONG_PRODUCT_ACC, 1'b1, 32'h12345678, K_HI, 5},
    '{OP_SIGNED_HALF_PRODUCT, 1'b0, 32'h0, K_UNIT, 1},
    '{OP_SIGNED_HALF_PRODUCT_ACC, 1'b0, 32'h0, K_LO, 2},
    '{OP_SIGNED_WORD_HALF_PRODUCT, 1'b0, 32'h0, K_UNIT, 2},
    '{OP_SIGNED_WORD_HALF_ACC, 1'b0, 32'h0, K_LO, 3},
    '{OP_SIGNED_HALF_LONG_ACC, 1'b0, 32'h0, K_HI, 3},
    '{OP_ACC_PRODUCT_ADD, 1'b0, 32'hFFFF8000, K_ACC, 1},
    '{OP_ACC_PRODUCT_ADD, 1'b0, 32'h0FFF0000, K_ACC, 2},
    '{OP_ACC_PRODUCT_ADD, 1'b0, 32'h12345678, K_UNIT, 3},
    '{OP_ACC_HALF_PRODUCT_ADD, 1'b0, 32'h0, K_ACC, 1},
    '{OP_ACC_PACKED_HALF_ADD, 1'b0, 32'h0, K_UNIT, 2},
    '{OP_ACC_LOAD_FROM_REGS, 1'b0, 32'h0, K_IND, 2},
    '{OP_ACC_LOAD_FROM_REGS, 1'b0, 32'h0, K_ACC, 2},
    '{OP_ACC_READ_TO_REGS, 1'b0, 32'h0, K_UNIT, 2},
    '{OP_ACC_READ_TO_REGS, 1'b0, 32'h0, K_HI, 3},
    '{OP_PRODUCT_32BIT, 1'b0, 32'h0, K_LATE, 3},
    '{OP_ACC_READ_TO_REGS, 1'b0, 32'h0, K_LATE, 3}
  };

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  mact_issue_model u_model (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .instr_ready (instr_ready),
    .issue_fire  (issue_fire),
    .issue_op    (issue_op),
    .instr_valid (instr_valid),
    .offer       (offer)
  );

  mact_timing u_dut (
    .sys_clk            (sys_clk),
    .resetn             (resetn),
    .instr_valid        (instr_valid),
    .instr_op           (offer.op),
    .flag_update        (offer.s),
    .multiplier_operand (offer.opnd),
    .dest_low_word      (offer.dlo),
    .dest_high_word     (offer.dhi),
    .src_a_idx          (offer.src[0]),
    .src_b_idx          (offer.src[1]),
    .src_c_idx          (offer.src[2]),
    .src_valid          (offer.sv),
    .src_late           (offer.late),
    .instr_ready        (instr_ready),
    .issue_fire         (issue_fire),
    .issue_op           (issue_op)
  );

  // ------------------------------------------------------------
  // Compare, build and sequence helpers
  // ------------------------------------------------------------
  task automatic check_num(input int got, input int exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic check_sig(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // Register 0 is never a destination, so rd 0 means no source
  function automatic mact_instr_t mk(input mact_op_t op, input logic s,
      input logic [31:0] v, input logic [4:0] d, input logic [4:0] rd,
      input logic [2:0] late);
    mk = '0;
    mk.op = op;
    mk.s = s;
    mk.opnd = v;
    mk.dlo = d;
    mk.dhi = d + 5'h01;
    mk.src[0] = rd;
    mk.sv = (rd != 5'h00) ? 3'h1 : 3'h0;
    mk.late = late;
  endfunction

  task automatic push_wait(input mact_instr_t a, input mact_instr_t b,
      input int n);
    int k;
    @(posedge sys_clk);
    u_model.fire_t.delete();
    u_model.fire_op.delete();
    u_model.pend.push_back(a);
    u_model.pend.push_back(b);
    k = 0;
    while (u_model.fire_t.size() < n && k < 60) begin
      @(posedge sys_clk);
      k++;
    end
    check_num(u_model.fire_t.size(), n);
  endtask

  task automatic run_pair(input mact_row_t r, input int idx);
    mact_instr_t b;
    case (r.k)
      K_LO:    b = mk(OP_OTHER, 1'b0, 32'h0, 5'h03, 5'h01, 3'h0);
      K_HI:    b = mk(OP_OTHER, 1'b0, 32'h0, 5'h03, 5'h02, 3'h0);
      K_ACC:   b = mk(OP_OTHER, 1'b0, 32'h0, 5'h03, ACC_ENTRY, 3'h0);
      K_UNIT:  b = mk(r.op, r.s, r.v, 5'h03, 5'h00, 3'h0);
      K_LATE:  b = mk(OP_OTHER, 1'b0, 32'h0, 5'h03, 5'h01, 3'h1);
      default: b = mk(OP_OTHER, 1'b0, 32'h0, 5'h03, 5'h00, 3'h0);
    endcase
    push_wait(mk(r.op, r.s, r.v, 5'h01, 5'h00, 3'h0), b, 2);
    if (u_model.fire_t.size() == 2) begin
      check_num(u_model.fire_t[1] - u_model.fire_t[0], r.gap);
      check_sig({27'h0, u_model.fire_op[0]}, {27'h0, r.op});
      check_sig({27'h0, u_model.fire_op[1]}, {27'h0, b.op});
    end
    repeat (8) @(posedge sys_clk);
    $display("row %0d done", idx);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Watchdog: rows and hand tests need well under 3000 cycles
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    int seen_low;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check_sig({30'h0, instr_ready, issue_fire}, 32'h0);
    check_sig({27'h0, issue_op}, {27'h0, OP_OTHER});
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check_sig({31'h0, instr_ready}, 32'h1);
    $display("reset test done");
    foreach (rows[i]) begin
      run_pair(rows[i], i);
    end
    // Slow head fills the queue; offers wait, none is lost
    seen_low = 0;
    fork
      push_wait(mk(OP_PRODUCT_32BIT, 1'b1, 32'h12345678, 5'h01, 5'h00,
                   3'h0), mk(OP_OTHER, 1'b0, 32'h0, 5'h03, 5'h00, 3'h0), 4);
      begin
        repeat (2) @(posedge sys_clk);
        u_model.pend.push_back(mk(OP_OTHER, 1'b0, 32'h0, 5'h05, 5'h00, 3'h0));
        u_model.pend.push_back(mk(OP_OTHER, 1'b0, 32'h0, 5'h07, 5'h00, 3'h0));
        repeat (6) @(negedge sys_clk) seen_low += (instr_ready === 1'b0);
      end
    join
    check_sig({31'h0, seen_low > 0}, 32'h1);
    if (u_model.fire_t.size() == 4) begin
      check_num(u_model.fire_t[1] - u_model.fire_t[0], 4);
      check_num(u_model.fire_t[3] - u_model.fire_t[1], 2);
    end
    repeat (8) @(posedge sys_clk);
    $display("queue full test done");
    // Reset in mid-run leaves nothing pending
    push_wait(mk(OP_PRODUCT_32BIT, 1'b0, 32'h12345678, 5'h01, 5'h00, 3'h0),
              mk(OP_OTHER, 1'b0, 32'h0, 5'h03, 5'h01, 3'h0), 1);
    resetn <= 1'b0;
    repeat (2) @(negedge sys_clk);
    check_sig({30'h0, instr_ready, issue_fire}, 32'h0);
    @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    push_wait(mk(OP_OTHER, 1'b0, 32'h0, 5'h03, 5'h00, 3'h0),
              mk(OP_OTHER, 1'b0, 32'h0, 5'h05, 5'h01, 3'h0), 2);
    if (u_model.fire_t.size() == 2) begin
      check_num(u_model.fire_t[1] - u_model.fire_t[0], 1);
    end
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule
